// ---- pkg/tfpc_regs.svh ----
// register map, field positions, reset values and timing for the fan controller
`ifndef TFPC_REGS_SVH
`define TFPC_REGS_SVH
// =====================================================
// register offsets (byte addresses)
`define TFPC_ADR_FAN0_CFG 8'h00
`define TFPC_ADR_FAN1_CFG 8'h04
`define TFPC_ADR_LIMITS 8'h08
`define TFPC_ADR_THROTTLE 8'h0C
`define TFPC_ADR_STATUS 8'h10
`define TFPC_ADR_TEMPS 8'h14
`define TFPC_ADR_IRQ_STAT 8'h18
`define TFPC_ADR_IRQ_MASK 8'h1C
// =====================================================
// field positions
`define TFPC_CFG_MODE 0
`define TFPC_CFG_DUTY 3:1
`define TFPC_CFG_SRC 6:4
`define TFPC_LIM_LO 3:0
`define TFPC_LIM_MID 7:4
`define TFPC_LIM_UP 11:8
`define TFPC_LIM_CRIT 15:12
`define TFPC_LIM_HYST 17:16
`define TFPC_THR_EN 0
`define TFPC_THR_SRC 3:1
`define TFPC_STS_ZONE0 1:0
`define TFPC_STS_ZONE1 3:2
`define TFPC_STS_THR 4
`define TFPC_IRQ_THR 0
`define TFPC_IRQ_ZONE0 1
`define TFPC_IRQ_ZONE1 2
// =====================================================
// limit ranges in degrees celsius
`define TFPC_LO_BASE 8'h14
`define TFPC_MID_BASE 8'h28
`define TFPC_UP_BASE 8'h32
`define TFPC_CRIT_BASE 8'h3C
`define TFPC_LIM_STEP 8'h05
`define TFPC_LO_MAX 4'h8
`define TFPC_MID_MAX 4'h8
`define TFPC_UP_MAX 4'hA
`define TFPC_CRIT_MAX 4'hA
// =====================================================
// reset values
`define TFPC_RST_FAN0_CFG 7'h19
`define TFPC_RST_FAN1_CFG 7'h28
`define TFPC_RST_LIMITS 18'h18644
`define TFPC_RST_THROTTLE 4'h0
// =====================================================
// timing
`define TFPC_CLK_HZ 40000000
`define TFPC_PWM_HZ 25000
`define TFPC_DUTY_STEPS 7'h64
`endif

// ---- pkg/tfpc_pkg.sv ----
// types shared by the fan controller
package tfpc_pkg;
   typedef enum logic [1:0] {
      ZONE_STOPPED = 2'b00,
      ZONE_LOW = 2'b01,
      ZONE_MEDIUM = 2'b10,
      ZONE_FULL = 2'b11
   } tfpc_zone_t;

   typedef enum logic [2:0] {
      FIX_OFF = 3'b000,
      FIX_25 = 3'b001,
      FIX_50 = 3'b010,
      FIX_75 = 3'b011,
      FIX_100 = 3'b100
   } tfpc_fix_t;

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [1:0][6:0] cfg;
      logic [17:0] lim;
      logic [3:0] thr_cfg;
      logic [2:0][7:0] s1;
      logic [2:0][7:0] s2;
      logic [2:0][7:0] s3;
      logic [2:0][7:0] temp;
      tfpc_zone_t [1:0] zone;
      logic [11:0] pre;
      logic [6:0] step;
      logic [1:0][6:0] duty;
      logic [1:0] pwm;
      logic thr;
      logic [2:0] irq_st;
      logic [2:0] irq_mask;
      logic irq;
   } tfpc_state_t;
endpackage

// ---- rtl/tfpc_top.sv ----
// thermal fan pwm controller with wishbone registers and throttle request
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "tfpc_regs.svh"

// Operation
// - two fan outputs, processor and system, each configured on its own
// - fixed mode drives off, 25, 50, 75 or 100 percent duty
// - temperature mode maps four zones to fixed duty levels
// - running levels are low 25, medium 50, full 100 percent
// - below lower limit the fan is stopped; at it low duty
// - from middle limit up to upper limit medium duty
// - at or above upper limit full duty
// - lower limit 20 to 60 degrees in 5 degree steps
// - middle limit 40 to 80 degrees in 5 degree steps
// - upper limit 50 to 100 degrees in 5 degree steps
// - stepping down waits until temperature falls limit minus hysteresis 2..8
// - per fan enables for processor, board and memory sensors
// - hottest enabled sensor picks the zone
// - throttle request when enabled source reaches critical limit 60..110
// - throttling has global enable plus per sensor enables
// - system fan resets into fixed duty mode
module tfpc_top
   import tfpc_pkg::*;
#(
   parameter int PWM_HZ = `TFPC_PWM_HZ
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] temp_cpu_i,
   input wire logic [7:0] temp_board_i,
   input wire logic [7:0] temp_mem_i,
   output logic fan_cpu_pwm_o,
   output logic fan_sys_pwm_o,
   output logic throttle_o,
   output logic irq_o
);

   // =====================================================
   // timing
   localparam int PRESCALE = `TFPC_CLK_HZ / (PWM_HZ * int'(`TFPC_DUTY_STEPS));
   localparam logic [11:0] PRE_LAST = 12'(PRESCALE - 1);

   generate
      if (PRESCALE < 1 || PRESCALE > 4096) begin : g_bad_rate
         $error("pwm rate out of range for the prescaler");
      end
   endgenerate

   localparam tfpc_state_t RST_STATE = '{
      ack: 1'b0,
      rdat: 32'h0,
      cfg: {`TFPC_RST_FAN1_CFG, `TFPC_RST_FAN0_CFG},
      lim: `TFPC_RST_LIMITS,
      thr_cfg: `TFPC_RST_THROTTLE,
      s1: 24'h0,
      s2: 24'h0,
      s3: 24'h0,
      temp: 24'h0,
      zone: {ZONE_STOPPED, ZONE_STOPPED},
      pre: 12'h0,
      step: 7'h0,
      duty: 14'h0,
      pwm: 2'b00,
      thr: 1'b0,
      irq_st: 3'h0,
      irq_mask: 3'h0,
      irq: 1'b0
   };

   // =====================================================
   // helpers
   function automatic logic [3:0] clamp_idx(input logic [3:0] v, input logic [3:0] mx);
      clamp_idx = (v > mx) ? mx : v;
   endfunction

   function automatic logic [8:0] lim_deg(input logic [7:0] base, input logic [3:0] idx);
      lim_deg = {1'b0, 8'(base + 8'({4'h0, idx} * `TFPC_LIM_STEP))};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      merge = r;
   endfunction

   function automatic logic [7:0] hottest(input logic [2:0][7:0] t, input logic [2:0] en);
      logic [7:0] m;
      m = 8'h0;
      for (int i = 0; i < 3; i++) begin
         if (en[i] && t[i] > m) begin
            m = t[i];
         end
      end
      hottest = m;
   endfunction

   function automatic tfpc_zone_t zone_of(input logic [8:0] t, input logic [8:0] lo,
                                          input logic [8:0] mi, input logic [8:0] up);
      if (t >= up) begin
         zone_of = ZONE_FULL;
      end else if (t >= mi) begin
         zone_of = ZONE_MEDIUM;
      end else if (t >= lo) begin
         zone_of = ZONE_LOW;
      end else begin
         zone_of = ZONE_STOPPED;
      end
   endfunction

   function automatic logic [6:0] zone_duty(input tfpc_zone_t z);
      unique case (z)
         ZONE_STOPPED: zone_duty = 7'h00;
         ZONE_LOW: zone_duty = 7'h19;
         ZONE_MEDIUM: zone_duty = 7'h32;
         ZONE_FULL: zone_duty = `TFPC_DUTY_STEPS;
      endcase
   endfunction

   function automatic logic [6:0] fix_duty(input logic [2:0] c);
      unique case (c)
         FIX_OFF: fix_duty = 7'h00;
         FIX_25: fix_duty = 7'h19;
         FIX_50: fix_duty = 7'h32;
         FIX_75: fix_duty = 7'h4B;
         FIX_100: fix_duty = `TFPC_DUTY_STEPS;
         // unused codes fail safe to full speed
         default: fix_duty = `TFPC_DUTY_STEPS;
      endcase
   endfunction

   // =====================================================
   // state
   tfpc_state_t st_ff;
   tfpc_state_t nxt_st;

   logic req;
   logic [31:0] rd;
   logic [31:0] wv;
   logic [8:0] lo_deg;
   logic [8:0] mid_deg;
   logic [8:0] up_deg;
   logic [8:0] crit_deg;
   logic [8:0] hyst_deg;
   logic [8:0] hot;
   logic [2:0] ev;
   logic [2:0] clr;
   logic wrap;
   tfpc_zone_t raw_z;
   tfpc_zone_t hys_z;
   logic [1:0][6:0] target;
   logic [2:0] crit_hit;

   always_comb begin
      nxt_st = st_ff;
      ev = 3'h0;
      clr = 3'h0;
      target = 14'h0;
      raw_z = ZONE_STOPPED;
      hys_z = ZONE_STOPPED;
      hot = 9'h0;
      crit_hit = 3'h0;

      lo_deg = lim_deg(`TFPC_LO_BASE, st_ff.lim[`TFPC_LIM_LO]);
      mid_deg = lim_deg(`TFPC_MID_BASE, st_ff.lim[`TFPC_LIM_MID]);
      up_deg = lim_deg(`TFPC_UP_BASE, st_ff.lim[`TFPC_LIM_UP]);
      crit_deg = lim_deg(`TFPC_CRIT_BASE, st_ff.lim[`TFPC_LIM_CRIT]);
      hyst_deg = {6'h0, st_ff.lim[`TFPC_LIM_HYST], 1'b0} + 9'h002;

      // =====================================================
      // wishbone slave, one wait state
      req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
      nxt_st.ack = req;
      case (wb_adr_i)
         `TFPC_ADR_FAN0_CFG: rd = {25'h0, st_ff.cfg[0]};
         `TFPC_ADR_FAN1_CFG: rd = {25'h0, st_ff.cfg[1]};
         `TFPC_ADR_LIMITS: rd = {14'h0, st_ff.lim};
         `TFPC_ADR_THROTTLE: rd = {28'h0, st_ff.thr_cfg};
         `TFPC_ADR_STATUS: rd = {27'h0, st_ff.thr, st_ff.zone[1], st_ff.zone[0]};
         `TFPC_ADR_TEMPS: rd = {8'h0, st_ff.temp[2], st_ff.temp[1], st_ff.temp[0]};
         `TFPC_ADR_IRQ_STAT: rd = {29'h0, st_ff.irq_st};
         `TFPC_ADR_IRQ_MASK: rd = {29'h0, st_ff.irq_mask};
         // unmapped reads zero, writes dropped, still acked
         default: rd = 32'h0;
      endcase
      wv = merge(rd, wb_dat_i, wb_sel_i);
      nxt_st.rdat = (req & ~wb_we_i) ? rd : 32'h0;
      if (req & wb_we_i) begin
         case (wb_adr_i)
            `TFPC_ADR_FAN0_CFG: nxt_st.cfg[0] = wv[6:0];
            `TFPC_ADR_FAN1_CFG: nxt_st.cfg[1] = wv[6:0];
            `TFPC_ADR_LIMITS: begin
               // out of range selections clamp to the top step
               nxt_st.lim[`TFPC_LIM_LO] = clamp_idx(wv[`TFPC_LIM_LO], `TFPC_LO_MAX);
               nxt_st.lim[`TFPC_LIM_MID] = clamp_idx(wv[`TFPC_LIM_MID], `TFPC_MID_MAX);
               nxt_st.lim[`TFPC_LIM_UP] = clamp_idx(wv[`TFPC_LIM_UP], `TFPC_UP_MAX);
               nxt_st.lim[`TFPC_LIM_CRIT] = clamp_idx(wv[`TFPC_LIM_CRIT], `TFPC_CRIT_MAX);
               nxt_st.lim[`TFPC_LIM_HYST] = wv[`TFPC_LIM_HYST];
            end
            `TFPC_ADR_THROTTLE: nxt_st.thr_cfg = wv[3:0];
            `TFPC_ADR_IRQ_STAT: clr = wv[2:0];
            `TFPC_ADR_IRQ_MASK: nxt_st.irq_mask = wv[2:0];
            default: ;
         endcase
      end

      // =====================================================
      // sensor inputs: three stages, accept on agreement
      nxt_st.s1 = {temp_mem_i, temp_board_i, temp_cpu_i};
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      for (int i = 0; i < 3; i++) begin
         if (st_ff.s2[i] == st_ff.s3[i]) begin
            nxt_st.temp[i] = st_ff.s3[i];
         end
      end

      // =====================================================
      // zone tracking per fan
      for (int f = 0; f < 2; f++) begin
         hot = {1'b0, hottest(st_ff.temp, st_ff.cfg[f][`TFPC_CFG_SRC])};
         raw_z = zone_of(hot, lo_deg, mid_deg, up_deg);
         hys_z = zone_of(hot + hyst_deg, lo_deg, mid_deg, up_deg);
         // rise at once, fall past hysteresis
         if (raw_z >= st_ff.zone[f]) begin
            nxt_st.zone[f] = raw_z;
         end else if (hys_z < st_ff.zone[f]) begin
            nxt_st.zone[f] = hys_z;
         end
         if (st_ff.cfg[f][`TFPC_CFG_MODE]) begin
            target[f] = zone_duty(st_ff.zone[f]);
            ev[`TFPC_IRQ_ZONE0 + f] = (nxt_st.zone[f] != st_ff.zone[f]);
         end else begin
            target[f] = fix_duty(st_ff.cfg[f][`TFPC_CFG_DUTY]);
         end
      end

      // =====================================================
      // pwm period and boundary update
      wrap = (st_ff.pre == PRE_LAST) && (st_ff.step == `TFPC_DUTY_STEPS - 7'h01);
      if (st_ff.pre == PRE_LAST) begin
         nxt_st.pre = 12'h0;
         nxt_st.step = wrap ? 7'h00 : st_ff.step + 7'h01;
      end else begin
         nxt_st.pre = st_ff.pre + 12'h001;
      end
      if (wrap) begin
         nxt_st.duty = target;
      end
      for (int f = 0; f < 2; f++) begin
         nxt_st.pwm[f] = nxt_st.step < nxt_st.duty[f];
      end

      // =====================================================
      // critical compare per source
      for (int i = 0; i < 3; i++) begin
         crit_hit[i] = ({1'b0, st_ff.temp[i]} >= crit_deg);
      end
      nxt_st.thr = st_ff.thr_cfg[`TFPC_THR_EN] & |(crit_hit & st_ff.thr_cfg[`TFPC_THR_SRC]);
      ev[`TFPC_IRQ_THR] = nxt_st.thr & ~st_ff.thr;

      // new events beat a simultaneous clear
      nxt_st.irq_st = (st_ff.irq_st & ~clr) | ev;
      nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_mask);
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_ff <= RST_STATE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign wb_ack_o = st_ff.ack;
   assign wb_dat_o = st_ff.rdat;
   assign fan_cpu_pwm_o = st_ff.pwm[0];
   assign fan_sys_pwm_o = st_ff.pwm[1];
   assign throttle_o = st_ff.thr;
   assign irq_o = st_ff.irq;

endmodule
`default_nettype wire

// ---- verification/tfpc_assertions.sv ----
// port checker for the fan controller
`timescale 1ns/10ps
`default_nettype none
`include "tfpc_regs.svh"
module tfpc_checker #(
   parameter int PWM_HZ = 25000
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic fan_cpu_pwm_o,
   input wire logic throttle_o,
   input wire logic irq_o
);
   localparam int PER = 40000000 / (PWM_HZ * 100) * 100;
   logic [2:0] msk_ff;
   logic ten_ff;
   logic fan_ff;
   logic seen_ff;
   int gap_ff;
   int hc_ff;
   logic wr;
   logic rise;
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
   assign rise = fan_cpu_pwm_o & ~fan_ff;
   // ====
   // shadows load at the edge a write is taken, same edge as the register
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         msk_ff <= 3'h0;
         ten_ff <= 1'b0;
         fan_ff <= 1'b0;
         seen_ff <= 1'b0;
         gap_ff <= 0;
         hc_ff <= 0;
      end else begin
         if (wr && wb_adr_i == `TFPC_ADR_IRQ_MASK) msk_ff <= wb_dat_i[2:0];
         if (wr && wb_adr_i == `TFPC_ADR_THROTTLE) ten_ff <= wb_dat_i[0];
         fan_ff <= fan_cpu_pwm_o;
         seen_ff <= seen_ff | rise;
         gap_ff <= rise ? 1 : gap_ff + 1;
         hc_ff <= fan_cpu_pwm_o ? hc_ff + 1 : 0;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   property p_ack_lat;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   property p_ack_one;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack too long");
   property p_dat_idle;
      !wb_ack_o |-> wb_dat_o == 32'h0;
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   property p_irq_mask;
      msk_ff == 3'h0 && $past(msk_ff) == 3'h0 |-> !irq_o;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
   property p_thr_off;
      !ten_ff && !$past(ten_ff) |-> !throttle_o;
   endproperty
   a_thr_off: assert property (p_thr_off) else $error("throttle while disabled");
   property p_rst_quiet;
      $fell(sys_rst_i) |-> !(fan_cpu_pwm_o | throttle_o | irq_o | wb_ack_o);
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
   property p_rise;
      rise && seen_ff |-> gap_ff % PER == 0;
   endproperty
   a_rise: assert property (p_rise) else $error("pwm rise off period");
   property p_high;
      $fell(fan_cpu_pwm_o) |-> hc_ff % (PER / 4) == 0;
   endproperty
   a_high: assert property (p_high) else $error("pwm high time not a duty step");
   c_rise: cover property (rise && seen_ff);
   c_thr: cover property ($rose(throttle_o));
   c_irq: cover property ($rose(irq_o));
endmodule
bind tfpc_top tfpc_checker #(.PWM_HZ(PWM_HZ)) u_chk (.clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .fan_cpu_pwm_o, .throttle_o, .irq_o);
`default_nettype wire

// ---- verification/tfpc_sensor_model.sv ----
// temperature sensors: asynchronous, noisy while settling
`timescale 1ns/10ps
`default_nettype none
module tfpc_sensor_model #(
   parameter int SETTLE_NS = 7
) (
   input wire logic [23:0] tgt_i,
   output logic [7:0] temp_cpu_o,
   output logic [7:0] temp_board_o,
   output logic [7:0] temp_mem_o
);
   initial {temp_mem_o, temp_board_o, temp_cpu_o} = 24'h0;
   // ====
   // glitch before settling, so a sampled transient is never trusted
   always @(tgt_i) begin
      #(SETTLE_NS);
      {temp_mem_o, temp_board_o, temp_cpu_o} <= ~tgt_i;
      #3;
      {temp_mem_o, temp_board_o, temp_cpu_o} <= tgt_i;
   end
endmodule
`default_nettype wire

// ---- verification/tfpc_bench.sv ----
// self-checking bench with a behavioural zone, duty and throttle model
`timescale 1ns/10ps
`default_nettype none
`include "tfpc_regs.svh"
module tfpc_bench;
   localparam int PER = 400;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [23:0] tgt = 24'h0;
   logic [31:0] rdat;
   logic [7:0] tc, tb, tm;
   logic ack, fan0, fan1, thr, irq;
   int mismatches = 0;
   int comparisons = 0;
   int unsigned rs = 33;
   int lo = 40, mid = 60, up = 80, crit = 100, hy = 4, ten = 0, tsrc = 0;
   int md[2] = '{0, 0};
   int fx[2] = '{4, 4};
   int src[2] = '{1, 2};
   int mz[2] = '{0, 0};
   int tt[10] = '{30, 40, 59, 60, 80, 77, 75, 57, 55, 35};
   always #12.5 clk_i = ~clk_i;
   tfpc_top #(.PWM_HZ(100000)) DUT (.clk_i, .sys_rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .temp_cpu_i(tc),
      .temp_board_i(tb), .temp_mem_i(tm), .fan_cpu_pwm_o(fan0), .fan_sys_pwm_o(fan1), .throttle_o(thr),
      .irq_o(irq));
   tfpc_sensor_model u_sens (.tgt_i(tgt), .temp_cpu_o(tc), .temp_board_o(tb), .temp_mem_o(tm));
   // ====
   // model and bus helpers
   function automatic int unsigned rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   function automatic int zone_of(int t);
      return t >= up ? 3 : t >= mid ? 2 : t >= lo ? 1 : 0;
   endfunction
   function automatic int duty(int f);
      int fd[8] = '{0, 25, 50, 75, 100, 100, 100, 100};
      int zd[4] = '{0, 25, 50, 100};
      return md[f] ? zd[mz[f]] : fd[fx[f]];
   endfunction
   function automatic logic thr_exp();
      logic r;
      r = 1'b0;
      for (int s = 0; s < 3; s++) begin
         if (tsrc[s] && tgt[8 * s +: 8] >= crit) r = 1'b1;
      end
      return ten[0] && r;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic step();
      int hot;
      for (int f = 0; f < 2; f++) begin
         hot = 0;
         for (int s = 0; s < 3; s++) begin
            if (src[f][s] && tgt[8 * s +: 8] > hot) hot = tgt[8 * s +: 8];
         end
         if (zone_of(hot) > mz[f]) mz[f] = zone_of(hot);
         else if (zone_of(hot + hy) < mz[f]) mz[f] = zone_of(hot + hy);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      // ack and data read at the edge itself, before the design updates
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      if (n >= 20) chk(32'h0, 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic lim(input int a, input int b, input int c, input int d, input int h);
      wr(`TFPC_ADR_LIMITS, {14'h0, h[1:0], d[3:0], c[3:0], b[3:0], a[3:0]});
      a = a > 8 ? 8 : a;
      b = b > 8 ? 8 : b;
      c = c > 10 ? 10 : c;
      d = d > 10 ? 10 : d;
      lo = 20 + 5 * a;
      mid = 40 + 5 * b;
      up = 50 + 5 * c;
      crit = 60 + 5 * d;
      hy = 2 * h + 2;
      step();
      rd(`TFPC_ADR_LIMITS, {14'h0, h[1:0], d[3:0], c[3:0], b[3:0], a[3:0]});
   endtask
   task automatic cfg(input int f, input int m, input int c, input int s);
      md[f] = m;
      fx[f] = c;
      src[f] = s;
      wr(8'(4 * f), {25'h0, s[2:0], c[2:0], m[0]});
      step();
   endtask
   task automatic th(input int e, input int s);
      ten = e;
      tsrc = s;
      wr(`TFPC_ADR_THROTTLE, {28'h0, s[2:0], e[0]});
   endtask
   task automatic settemp(input logic [23:0] v);
      @(posedge clk_i);
      tgt <= v;
      #1;
      step();
   endtask
   task automatic irqchk(input logic e);
      repeat (2) @(posedge clk_i);
      #1;
      chk(irq, e);
   endtask
   task automatic settle();
      int h0, h1;
      h0 = 0;
      h1 = 0;
      repeat (PER + 20) @(posedge clk_i);
      repeat (PER) begin
         @(posedge clk_i);
         #1;
         h0 += fan0;
         h1 += fan1;
      end
      chk(h0, duty(0) * PER / 100);
      chk(h1, duty(1) * PER / 100);
      chk(thr, thr_exp());
      rd(`TFPC_ADR_TEMPS, {8'h0, tgt});
      rd(`TFPC_ADR_STATUS, {thr_exp(), mz[1][1:0], mz[0][1:0]});
   endtask
   task automatic end_sim();
      if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #(25 * 80000);
      mismatches++;
      end_sim();
   end
   initial begin
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd(`TFPC_ADR_FAN0_CFG, 32'h19);
      rd(`TFPC_ADR_FAN1_CFG, 32'h28);
      rd(`TFPC_ADR_LIMITS, 32'h18644);
      rd(8'h20, 32'h0);
      lim(15, 15, 15, 15, 3);
      for (int c = 0; c < 8; c++) begin
         cfg(0, 0, c, 1);
         cfg(1, 0, 7 - c, 2);
         settle();
      end
      lim(4, 4, 6, 8, 1);
      cfg(1, 0, 0, 2);
      cfg(0, 1, 0, 1);
      foreach (tt[i]) begin
         settemp({16'h0, 8'(tt[i])});
         settle();
      end
      for (int i = 0; i < 12; i++) begin
         lim(rnd() % 16, rnd() % 16, rnd() % 16, rnd() % 16, rnd() % 4);
         cfg(i % 2, 1, 0, rnd() % 8);
         th(rnd() % 2, rnd() % 8);
         settemp(rnd() & 24'h7F7F7F);
         settle();
      end
      lim(4, 4, 6, 0, 1);
      settemp(24'h0);
      settle();
      th(1, 1);
      wr(`TFPC_ADR_IRQ_STAT, 32'h7);
      wr(`TFPC_ADR_IRQ_MASK, 32'h1);
      irqchk(1'b0);
      settemp(24'h40);
      settle();
      irqchk(1'b1);
      wr(`TFPC_ADR_IRQ_MASK, 32'h0);
      irqchk(1'b0);
      wr(`TFPC_ADR_IRQ_STAT, 32'h1);
      wr(`TFPC_ADR_IRQ_MASK, 32'h1);
      irqchk(1'b0);
      end_sim();
   end
endmodule
`default_nettype wire
